/* File: rtl/csp_device.sv */
`default_nettype none
module csp_device (
  input wire logic clk,
  input wire logic srst,
  csp_if.dev link,
  input wire logic [2:0] tx_done,
  output logic [2:0] tx_request,
  output logic config_mode,
  output logic in_reset
);
  import csp_pkg::*;

  typedef enum {ST_CMD, ST_ADDR, ST_MASK, ST_BMDATA, ST_WRITE, ST_READ, ST_STATUS,
    ST_IGNORE} csp_state_e;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic cs_q1; // select, first stage
  logic cs_q2; // select, synchronised
  logic sck_q1; // clock, first stage
  logic sck_q2; // clock, synchronised
  logic sck_q3; // clock, previous value for edges
  logic si_q1; // data in, first stage
  logic si_q2; // data in, synchronised, aligned with sck_q2

  // all three pins see the same delay so data stays aligned to the clock
  always_ff @(posedge clk)
  begin
    if (srst) // select reads as deselected until the pin is known
    begin
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
    end
    else
    begin
      cs_q1 <= link.cs_n;
      cs_q2 <= cs_q1;
    end
    sck_q1 <= link.sck;
    sck_q2 <= sck_q1;
    sck_q3 <= sck_q2;
    si_q1 <= link.mosi;
    si_q2 <= si_q1;
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  csp_state_e state; // command decoder state
  logic [7:0] opcode; // current instruction
  logic [6:0] rx_sh; // bits of the byte being received
  logic [2:0] rx_cnt; // bits received in this byte
  logic [7:0] ptr; // register address pointer
  logic [7:0] mask; // bit modify mask
  logic [7:0] tx_sh; // bits still to send
  logic [2:0] tx_cnt; // bits left in the byte being sent
  logic [7:0] rst_cnt; // remaining reset hold cycles
  logic [7:0] mem [CSP_REGS]; // register file

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // edges only count while selected; mode 0,0 and 1,1 share edge meaning
  wire sck_rise = sck_q2 && !sck_q3 && !cs_q2;
  wire sck_fall = !sck_q2 && sck_q3 && !cs_q2;
  wire [7:0] rx_byte = {rx_sh, si_q2}; // byte including bit just sampled
  wire byte_done = sck_rise && (rx_cnt == 3'h7); // eighth bit sampled
  wire busy_rst = (rst_cnt != 8'h00); // reset hold running
  wire is_rts = ((rx_byte & CSP_OP_RTS_MASK) == CSP_OP_RTS); // request to send
  wire cmd_done = byte_done && (state == ST_CMD); // instruction byte complete
  wire [6:0] ptr_idx = csp_map(ptr);
  wire [7:0] cur = mem[ptr_idx]; // addressed register
  wire [7:0] intf = mem[CSP_A_INTFLAG]; // interrupt flags
  wire [2:0] transmit_request_flag = {mem[csp_txctrl(2)][CSP_TRANSMIT_REQUEST_FLAG_BIT], mem[csp_txctrl(1)][CSP_TRANSMIT_REQUEST_FLAG_BIT],
    mem[csp_txctrl(0)][CSP_TRANSMIT_REQUEST_FLAG_BIT]}; // transmit_request_flag of each buffer
  wire [7:0] status = {intf[4], transmit_request_flag[2], intf[3], transmit_request_flag[1], intf[2], transmit_request_flag[0], intf[1],
    intf[0]}; // status summary
  wire [7:0] out_src = (state == ST_READ) ? cur : status; // next byte to send
  wire wr_write = byte_done && (state == ST_WRITE);
  wire wr_bm = byte_done && (state == ST_BMDATA) && csp_bm_ok(ptr_idx);
  wire [7:0] bm_val = (cur & ~mask) | (rx_byte & mask);
  wire [7:0] wr_val = wr_bm ? bm_val : rx_byte; // value committed
  // zero select field sets nothing
  wire [2:0] rts_set = (cmd_done && is_rts) ? rx_byte[2:0] : 3'h0;

  // ----------------------------------------
  // reset hold counter
  // ----------------------------------------
  // external reset and reset opcode both start the hold
  always_ff @(posedge clk)
  begin
    if (srst)
      rst_cnt <= CSP_RST_CYCLES;
    else if (cmd_done && rx_byte == CSP_OP_RESET)
      rst_cnt <= CSP_RST_CYCLES;
    else if (busy_rst)
      rst_cnt <= rst_cnt - 8'h01;
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // defaults held for the whole reset hold; request set wins over done clear
  always_ff @(posedge clk)
  begin
    if (srst || busy_rst)
    begin
      for (int i = 0; i < CSP_REGS; i++)
        mem[i] <= csp_default(7'(i));
    end
    else
    begin
      if (wr_write || wr_bm)
        mem[ptr_idx] <= wr_val;
      for (int b = 0; b < 3; b++)
      begin
        if (rts_set[b])
          mem[csp_txctrl(b)][CSP_TRANSMIT_REQUEST_FLAG_BIT] <= 1'b1;
        else if (tx_done[b])
          mem[csp_txctrl(b)][CSP_TRANSMIT_REQUEST_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // receive shifter and command sequencer
  // ----------------------------------------
  // deselect throws away partial byte and the whole command context
  always_ff @(posedge clk)
  begin
    if (srst || cs_q2)
    begin
      state <= ST_CMD;
      rx_cnt <= 3'h0;
      rx_sh <= 7'h00;
      opcode <= 8'h00;
      ptr <= 8'h00;
      mask <= 8'h00;
    end
    else if (busy_rst)
      state <= ST_IGNORE;
    else
    begin
      if (sck_rise)
      begin
        rx_sh <= rx_byte[6:0];
        rx_cnt <= rx_cnt + 3'h1;
      end
      if (byte_done)
      begin
        case (state)
          ST_CMD:
          begin
            opcode <= rx_byte;
            if (rx_byte == CSP_OP_READ || rx_byte == CSP_OP_WRITE || rx_byte == CSP_OP_BITMOD)
              state <= ST_ADDR;
            else if (rx_byte == CSP_OP_STATUS)
              state <= ST_STATUS;
            else
              state <= ST_IGNORE;
          end
          ST_ADDR:
          begin
            ptr <= rx_byte;
            if (opcode == CSP_OP_READ)
              state <= ST_READ;
            else if (opcode == CSP_OP_WRITE)
              state <= ST_WRITE;
            else
              state <= ST_MASK;
          end
          ST_MASK:
          begin
            mask <= rx_byte;
            state <= ST_BMDATA;
          end
          ST_BMDATA:
            state <= ST_IGNORE;
          ST_WRITE:
            ptr <= ptr + 8'h01;
          default:
            state <= state;
        endcase
      end
      // a read advances the pointer as each byte is loaded for shifting
      if (sck_fall && state == ST_READ && tx_cnt == 3'h0)
        ptr <= ptr + 8'h01;
    end
  end

  // ----------------------------------------
  // transmit shifter
  // ----------------------------------------
  // output changes only on falling clock; undriven when deselected
  always_ff @(posedge clk)
  begin
    if (srst || cs_q2)
    begin
      tx_cnt <= 3'h0;
      tx_sh <= 8'h00;
      link.miso <= 1'b0;
      link.miso_oe_n <= 1'b1;
    end
    else
    begin
      link.miso_oe_n <= 1'b0;
      if (sck_fall && (state == ST_READ || state == ST_STATUS))
      begin
        if (tx_cnt == 3'h0)
        begin
          link.miso <= out_src[7];
          tx_sh <= {out_src[6:0], 1'b0};
          tx_cnt <= 3'h7;
        end
        else
        begin
          link.miso <= tx_sh[7];
          tx_sh <= {tx_sh[6:0], 1'b0};
          tx_cnt <= tx_cnt - 3'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // user-side outputs
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_request <= 3'h0;
      config_mode <= 1'b1;
      in_reset <= 1'b1;
    end
    else
    begin
      tx_request <= transmit_request_flag;
      config_mode <= (mem[CSP_A_CANSTAT][7:5] == CSP_MODE_CONFIG);
      in_reset <= busy_rst;
    end
  end
endmodule // csp_device
`default_nettype wire

/* File: rtl/csp_fifo.sv */
`default_nettype none
module csp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  logic [WIDTH-1:0] mem [DEPTH]; // word storage
  logic [AW-1:0] wr_ptr; // next write slot
  logic [AW-1:0] rd_ptr; // next read slot
  logic [AW:0] count; // words held
  wire push = in_valid && in_ready; // word accepted
  wire pop = out_valid && out_ready; // word taken

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // pointer and count update
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // data write
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
endmodule // csp_fifo
`default_nettype wire

/* File: rtl/csp_host.sv */
`default_nettype none
module csp_host (
  input wire logic clk,
  input wire logic srst,
  csp_if.host link,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic busy
);
  import csp_pkg::*;

  typedef enum {H_IDLE, H_LOW, H_HIGH, H_NEXT, H_END, H_GAP} csp_hstate_e;

  // ----------------------------------------
  // command fifo
  // ----------------------------------------
  logic f_valid; // byte waiting
  logic [CSP_FIFO_WIDTH-1:0] f_data; // {last, byte}
  logic f_ready; // byte taken this cycle
  logic in_ready; // fifo has room

  csp_fifo #(.WIDTH(CSP_FIFO_WIDTH), .DEPTH(CSP_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(cmd_valid),
    .in_data({cmd_last, cmd_data}),
    .in_ready(in_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  csp_hstate_e state; // frame sequencer
  logic [3:0] cnt; // half period counter
  logic [2:0] bit_cnt; // bits left in the byte
  logic [7:0] sh; // outgoing byte
  logic [7:0] rx; // incoming byte
  logic last; // current byte ends the frame
  logic so_q1; // serial output, first stage
  logic so_q2; // serial output, synchronised

  wire half_done = (cnt == 4'h0); // half period elapsed
  wire load = f_valid && (state == H_IDLE || state == H_NEXT); // take next byte
  assign f_ready = load;

  // device output crosses from the device's sampling back to us
  always_ff @(posedge clk)
  begin
    so_q1 <= link.so_line;
    so_q2 <= so_q1;
  end

  // ----------------------------------------
  // serial sequencer, mode 0,0
  // ----------------------------------------
  // select held low for the whole frame, a fresh fall starts each one
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= H_IDLE;
      cnt <= 4'h0;
      bit_cnt <= 3'h0;
      sh <= 8'h00;
      rx <= 8'h00;
      last <= 1'b0;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.mosi <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      cnt <= half_done ? 4'(CSP_SCK_HALF - 1) : cnt - 4'h1;
      case (state)
        H_IDLE, H_NEXT:
        begin
          if (load)
          begin
            link.cs_n <= 1'b0;
            link.mosi <= f_data[7];
            sh <= {f_data[6:0], 1'b0};
            last <= f_data[8];
            bit_cnt <= 3'h7;
            cnt <= 4'(CSP_SCK_HALF - 1);
            state <= H_LOW;
          end
        end
        H_LOW:
        begin
          if (half_done)
          begin
            link.sck <= 1'b1;
            rx <= {rx[6:0], so_q2};
            state <= H_HIGH;
          end
        end
        H_HIGH:
        begin
          if (half_done)
          begin
            link.sck <= 1'b0;
            if (bit_cnt == 3'h0)
            begin
              rsp_valid <= 1'b1;
              rsp_data <= rx;
              state <= last ? H_END : H_NEXT;
            end
            else
            begin
              link.mosi <= sh[7];
              sh <= {sh[6:0], 1'b0};
              bit_cnt <= bit_cnt - 3'h1;
              state <= H_LOW;
            end
          end
        end
        H_END:
        begin
          if (half_done)
          begin
            link.cs_n <= 1'b1;
            state <= H_GAP;
          end
        end
        H_GAP:
        begin
          if (half_done)
            state <= H_IDLE;
        end
        default:
          state <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // user-side flags
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_ready <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      cmd_ready <= in_ready;
      busy <= (state != H_IDLE);
    end
  end
endmodule // csp_host
`default_nettype wire

/* File: rtl/csp_if.sv */
`default_nettype none
interface csp_if;
  logic cs_n; // chip select, low selects the device
  logic sck; // serial clock from the host
  logic mosi; // serial data into the device
  logic miso; // serial data driven by the device
  logic miso_oe_n; // low while the device drives miso
  logic so_line; // level seen on the serial output wire

  // undriven wire reads high
  assign so_line = miso_oe_n ? 1'b1 : miso;

  modport dev (input cs_n, input sck, input mosi, output miso, output miso_oe_n);
  modport host (output cs_n, output sck, output mosi, input so_line);
endinterface
`default_nettype wire

/* File: rtl/csp_pkg.sv */
`default_nettype none
package csp_pkg;
  // ----------------------------------------
  // instruction bytes
  // ----------------------------------------
  localparam logic [7:0] CSP_OP_RESET = 8'hc0; // re-initialise registers
  localparam logic [7:0] CSP_OP_READ = 8'h03; // auto-increment read
  localparam logic [7:0] CSP_OP_WRITE = 8'h02; // auto-increment write
  localparam logic [7:0] CSP_OP_RTS = 8'h80; // request to send, low three bits select
  localparam logic [7:0] CSP_OP_RTS_MASK = 8'hf8; // fixed part of request to send
  localparam logic [7:0] CSP_OP_STATUS = 8'ha0; // repeating status poll
  localparam logic [7:0] CSP_OP_BITMOD = 8'h05; // masked bit update

  // ----------------------------------------
  // timing and sizes
  // ----------------------------------------
  localparam logic [7:0] CSP_RST_CYCLES = 8'h80; // reset hold, oscillator_clock cycles
  localparam int CSP_SCK_HALF = 8; // clk cycles per serial clock half period
  localparam int CSP_FIFO_WIDTH = 9; // command byte plus last flag
  localparam int CSP_FIFO_DEPTH = 4; // words in host command fifo
  localparam int CSP_REGS = 128; // register locations held in flops

  // ----------------------------------------
  // register locations and reset values
  // ----------------------------------------
  localparam logic [6:0] CSP_A_CANSTAT = 7'h0e; // status, mirrored in every column
  localparam logic [6:0] CSP_A_CANCTRL = 7'h0f; // control, mirrored in every column
  localparam logic [6:0] CSP_A_INTFLAG = 7'h2c; // interrupt flags
  localparam logic [7:0] CSP_CANSTAT_RST = 8'h80; // configuration mode
  localparam logic [7:0] CSP_CANCTRL_RST = 8'he7; // control after reset
  localparam logic [2:0] CSP_MODE_CONFIG = 3'h4; // operating mode field value
  localparam int CSP_TRANSMIT_REQUEST_FLAG_BIT = 3; // transmit_request_flag in tx_buffer_control

  // upper nibble is column, lower nibble is row; rows e and f of every column map to column 0
  function automatic logic [6:0] csp_map(input logic [7:0] a);
    if (a[3:1] == 3'h7)
      csp_map = {3'h0, a[3:0]};
    else
      csp_map = a[6:0];
  endfunction

  // tx_buffer_control location of buffer n
  function automatic logic [6:0] csp_txctrl(input int n);
    csp_txctrl = {3'(n + 3), 4'h0};
  endfunction

  // locations that accept a masked bit update
  function automatic logic csp_bm_ok(input logic [6:0] a);
    csp_bm_ok = (a == 7'h0c) || (a == 7'h0d) || (a == CSP_A_CANCTRL) ||
      (a >= 7'h28 && a <= 7'h2d) || (a == 7'h30) || (a == 7'h40) ||
      (a == 7'h50) || (a == 7'h60) || (a == 7'h70);
  endfunction

  // value of a location after reset
  function automatic logic [7:0] csp_default(input logic [6:0] a);
    if (a == CSP_A_CANSTAT)
      csp_default = CSP_CANSTAT_RST;
    else if (a == CSP_A_CANCTRL)
      csp_default = CSP_CANCTRL_RST;
    else
      csp_default = 8'h00;
  endfunction
endpackage
`default_nettype wire

/* File: verif/can_ctrl_spi_command_port_test.sv */
`default_nettype none
module can_ctrl_spi_command_port_test;
  import csp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0; // 40 MHz system clock
  logic srst = 1'b1; // synchronous reset
  logic cmd_valid = 1'b0; // byte offered to host
  logic [7:0] cmd_data = 8'h00; // byte to send
  logic cmd_last = 1'b0; // closes frame
  logic [2:0] tx_done = 3'h0; // transmit completion per buffer
  wire cmd_ready, rsp_valid, busy, config_mode, in_reset;
  wire [7:0] rsp_data;
  wire [2:0] tx_request;
  logic [7:0] rsp_q[$]; // bytes read back in the current frame
  int errors = 0;
  int total_checks = 0;
  int cycles = 0; // run length for the hang guard
  int hold_cnt = 0; // consecutive cycles in reset hold
  logic cut_frame = 1'b0; // resets the host and checker, not the device, to cut a frame short

  csp_if link ();
  csp_device csp_device_i (.clk(clk), .srst(srst), .link(link), .tx_done(tx_done),
    .tx_request(tx_request), .config_mode(config_mode), .in_reset(in_reset));
  csp_host csp_host_i (.clk(clk), .srst(srst || cut_frame), .link(link), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy));
  csp_checker csp_checker_i (.clk(clk), .srst(srst || cut_frame), .cs_n(link.cs_n),
    .sck(link.sck), .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n));

  // clock generator
  always #12.5 clk = ~clk;

  // collect read-back bytes, track reset hold, cut a hang short
  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1)
      rsp_q.push_back(rsp_data);
    hold_cnt <= (in_reset === 1'b1) ? hold_cnt + 1 : 0;
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  // offer each byte of one frame to the host fifo
  task automatic push(input logic [7:0] b[$]);
    int w;
    foreach (b[i])
    begin
      w = 0;
      do @(negedge clk); while (cmd_ready !== 1'b1 && ++w < 1000);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_data <= b[i];
      cmd_last <= (i == b.size() - 1);
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(posedge clk);
    end
  endtask

  // one whole frame through the host, waits until it is over
  task automatic send(input logic [7:0] b[$]);
    int w;
    rsp_q.delete();
    push(b);
    w = 0;
    while ((rsp_q.size() < b.size() || busy !== 1'b0) && w < 4000)
    begin
      @(negedge clk);
      w++;
    end
    if (w >= 4000)
    begin
      $display("CHECK FAILED t=%0t frame did not finish", $time);
      errors++;
    end
    repeat (4) @(negedge clk);
  endtask

  // read consecutive registers and compare each
  task automatic rd(input logic [7:0] a, input logic [7:0] exp[$]);
    logic [7:0] q[$];
    q = '{CSP_OP_READ, a};
    foreach (exp[i]) q.push_back(8'h00);
    send(q);
    foreach (exp[i]) check(rsp_q[i + 2], exp[i]);
  endtask

  // wait out the reset hold, return its length
  task automatic wait_hold(output int len);
    int w;
    w = 0;
    len = 0;
    while (in_reset !== 1'b0 && w < 400)
    begin
      @(negedge clk);
      w++;
    end
    // the count already holds the last high cycle here
    len = hold_cnt;
    if (w >= 400)
    begin
      $display("CHECK FAILED t=%0t reset hold did not end", $time);
      errors++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int len;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    wait_hold(len);
    check({7'h00, config_mode}, 8'h01);
    rd(8'h3e, '{CSP_CANSTAT_RST, CSP_CANCTRL_RST});
    // auto-increment write, then read back
    send('{CSP_OP_WRITE, 8'h20, 8'h11, 8'h22, 8'h33});
    rd(8'h20, '{8'h11, 8'h22, 8'h33});
    // a frame cut inside its second data byte keeps only the first
    push('{CSP_OP_WRITE, 8'h24, 8'h5a, 8'hc3});
    repeat (410) @(posedge clk);
    cut_frame <= 1'b1;
    repeat (4) @(posedge clk);
    cut_frame <= 1'b0;
    repeat (4) @(negedge clk);
    rd(8'h24, '{8'h5a, 8'h00});
    // masked update on an allowed and a refused location
    send('{CSP_OP_WRITE, 8'h2b, 8'h3c});
    send('{CSP_OP_BITMOD, 8'h2b, 8'hf0, 8'ha5});
    rd(8'h2b, '{8'hac});
    send('{CSP_OP_BITMOD, 8'h21, 8'hff, 8'h00});
    rd(8'h21, '{8'h22});
    // request to send with no select, then buffers 0 and 2
    send('{CSP_OP_RTS});
    check({5'h00, tx_request}, 8'h00);
    send('{CSP_OP_RTS | 8'h05});
    check({5'h00, tx_request}, 8'h05);
    rd(8'h30, '{8'h08});
    // status repeats while clocked
    send('{CSP_OP_STATUS, 8'h00, 8'h00});
    check(rsp_q[1], 8'h44);
    check(rsp_q[2], 8'h44);
    @(posedge clk);
    tx_done <= 3'h7;
    @(posedge clk);
    tx_done <= 3'h0;
    repeat (2) @(negedge clk);
    check({5'h00, tx_request}, 8'h00);
    // unknown opcode must not write
    send('{8'hff, 8'h20, 8'h55});
    rd(8'h20, '{8'h11});
    // reset instruction restores defaults after the hold
    send('{CSP_OP_RESET});
    wait_hold(len);
    check({7'h00, len >= 128 && len <= 132}, 8'h01);
    check({7'h00, config_mode}, 8'h01);
    rd(8'h20, '{8'h00});
    rd(8'h0e, '{CSP_CANSTAT_RST, CSP_CANCTRL_RST});
    report_and_stop();
  end
endmodule // can_ctrl_spi_command_port_test
`default_nettype wire

/* File: verif/csp_checker.sv */
`default_nettype none
module csp_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic sck_q; // serial clock one cycle back
  logic [2:0] bit_cnt; // rising serial clock edges in frame, modulo 8
  wire sck_rise = sck & ~sck_q; // rising edge seen this cycle

  // delay the serial clock
  always_ff @(posedge clk)
    sck_q <= sck;

  // count bits of the current frame
  always_ff @(posedge clk)
    if (srst || cs_n)
      bit_cnt <= 3'h0;
    else if (sck_rise)
      bit_cnt <= bit_cnt + 3'h1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence sck_quiet;
    !sck [*8];
  endsequence

  a_output_released: assert property (cs_n [*5] |-> miso_oe_n)
    else $error("serial output driven while deselected");
  a_drive_after_select: assert property ($fell(cs_n) |-> ##[1:5] !miso_oe_n)
    else $error("serial output not driven after select");
  a_out_on_fall: assert property (!miso_oe_n && $past(!miso_oe_n) && $changed(miso) |->
    !sck && ($past(sck, 3) || $past(sck, 4) || $past(sck, 5) || $past(sck, 6)))
    else $error("serial output changed away from a falling edge");
  a_clock_idle_low: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  a_data_held_high: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("serial input moved while clock high");
  a_clock_high_time: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
    else $error("serial clock high phase not eight cycles");
  a_select_setup: assert property ($fell(cs_n) |-> sck_quiet)
    else $error("serial clock moved right after select");
  a_whole_bytes: assert property ($rose(cs_n) |-> bit_cnt == 3'h0)
    else $error("frame ended inside a byte");
endmodule // csp_checker
`default_nettype wire
